// ### rtl/lves_top.sv
/*
  Local vector entries for performance, thermal, error and extended
  sources; error status capture; spurious delivery; software enable
  and focus checking.
  Assumes a core-side arbiter supplies the acknowledged vector, the
  task priority and the in-service and pending bit maps.
*/
`default_nettype none

module lves_top
  import lves_pkg::*;
#(
  parameter int N_EXT_SRC = 4
)
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Interrupt sources
  input wire logic perf_ovf,
  input wire logic thermal_evt,
  input wire logic [N_EXT_SRC-1:0] ext_src_evt,
  // Entry delivery to core
  output logic ent_req_valid,
  output logic [7:0] ent_req_vec,
  output logic [2:0] ent_req_mt,
  input wire logic ent_req_ready,
  // Message error events
  input wire logic send_unaccepted,
  input wire logic recv_unaccepted,
  input wire logic send_bad_vec,
  // Incoming messages
  input wire logic msg_valid,
  input wire logic [2:0] msg_type,
  input wire logic [7:0] msg_vec,
  input wire logic msg_from_pin,
  output logic msg_accept,
  output logic focus_hit,
  input wire logic [255:0] in_service_bits,
  input wire logic [255:0] request_pending_bits,
  // Acknowledge
  input wire logic ack_req,
  input wire logic [7:0] ack_vec,
  input wire logic [7:0] task_prio,
  output logic core_vec_valid,
  output logic [7:0] core_vec,
  output logic core_spurious,
  output logic in_service_set,
  // Status
  output logic sw_enabled
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK = 2'b01,
    ST_DONE = 2'b11
  } lves_st_t;

  localparam int SEL_W = 2;

  logic [31:0] spur_q;
  logic [SEL_W*N_EXT_SRC-1:0] ext_sel_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_d;
  logic [31:0] ent_val [N_ENT];
  logic [N_ENT-1:0] ent_wr;
  logic [N_ENT-1:0] ent_evt;
  logic [N_ENT-1:0] ent_pend;
  logic [N_ENT-1:0] ent_bad;
  logic [N_ENT-1:0] ent_take;
  logic [N_EXT_ENT-1:0] ext_evt;
  logic [7:0] err_set;
  logic [7:0] err_flags;
  logic [7:0] esr;
  logic err_evt;
  logic hit_spur;
  logic hit_esr;
  logic hit_feat;
  logic hit_sel;
  logic mapped;
  logic esr_wr;
  logic bad_access;
  logic sw_en;
  logic focus_check_control;
  logic sys_type;
  logic gated_type;
  logic msg_bad;
  lves_st_t st_q;
  logic [7:0] ack_vec_q;
  logic vld_q;
  logic spur_out_q;
  logic in_service_set_q;
  logic [7:0] cvec_q;
  logic spur_hit;

  assign sw_en = spur_q[SW_EN_BIT];
  assign focus_check_control = spur_q[FOCUS_BIT];

  // Address decode
  always_comb
  begin
    ent_wr = '0;
    hit_spur = reg_addr == OFF_SPUR;
    hit_esr = reg_addr == OFF_ESR;
    hit_feat = reg_addr == OFF_FEAT;
    hit_sel = reg_addr == OFF_EXT_SEL;
    mapped = hit_spur | hit_esr | hit_feat | hit_sel;
    for (int e = 0; e < N_ENT; e++)
    begin
      if (reg_addr == lves_ent_off(e))
      begin
        ent_wr[e] = reg_wr;
        mapped = 1'b1;
      end
    end
  end

  assign bad_access = (reg_wr || reg_rd) && !mapped;
  assign esr_wr = reg_wr && hit_esr;

  // Read mux; reserved bits read zero
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (hit_spur)
      rd_d = spur_q;
    if (hit_esr)
      rd_d = {24'h00_0000, esr};
    if (hit_feat)
      rd_d[EXT_CNT_LSB +: 8] = 8'(N_EXT_ENT);
    if (hit_sel)
      rd_d[SEL_W*N_EXT_SRC-1:0] = ext_sel_q;
    for (int e = 0; e < N_ENT; e++)
    begin
      if (reg_addr == lves_ent_off(e))
        rd_d = ent_val[e];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata_q <= 32'h0000_0000;
    else if (ce)
      rdata_q <= reg_rd ? rd_d : 32'h0000_0000;
  end

  assign reg_rdata = rdata_q;

  // Spurious vector, enable and focus control
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      spur_q <= SPUR_RST;
    else if (ce && reg_wr && hit_spur)
      spur_q <= {22'h00_0000, reg_wdata[9:0]};
  end

  // Extended source select
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ext_sel_q <= '0;
    else if (ce && reg_wr && hit_sel)
      ext_sel_q <= reg_wdata[SEL_W*N_EXT_SRC-1:0];
  end

  // Route each extended source to its chosen entry
  always_comb
  begin
    ext_evt = '0;
    for (int s = 0; s < N_EXT_SRC; s++)
    begin
      if (ext_src_evt[s])
        ext_evt[ext_sel_q[s*SEL_W +: SEL_W]] = 1'b1;
    end
  end

  assign ent_evt[ENT_THERM] = thermal_evt;
  assign ent_evt[ENT_PERF] = perf_ovf;
  assign ent_evt[ENT_ERR] = err_evt;
  assign ent_evt[N_ENT-1:N_FIXED_ENT] = ext_evt;

  // Three fixed entries, then N_EXT_ENT extended entries
  for (genvar e = 0; e < N_ENT; e++)
  begin : g_ent
    lves_entry u_entry (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .sw_en(sw_en),
      .wr_en(ent_wr[e]),
      .wr_data(reg_wdata),
      .evt(ent_evt[e]),
      .take(ent_take[e]),
      .value(ent_val[e]),
      .pend(ent_pend[e]),
      .bad_vec(ent_bad[e])
    );
  end

  // Lowest-index pending entry goes to the core first
  always_comb
  begin
    ent_take = '0;
    ent_req_vec = 8'h00;
    ent_req_mt = 3'h0;
    for (int e = N_ENT - 1; e >= 0; e--)
    begin
      if (ent_pend[e])
      begin
        ent_take = '0;
        ent_take[e] = ent_req_ready;
        ent_req_vec = ent_val[e][VEC_LSB +: 8];
        ent_req_mt = ent_val[e][MT_LSB +: 3];
      end
    end
  end

  assign ent_req_valid = |ent_pend;

  // Incoming message acceptance
  always_comb
  begin
    sys_type = msg_type inside {MT_SMI, MT_NMI, MT_INIT, MT_START, MT_RREAD};
    gated_type = msg_type inside {MT_FIXED, MT_LOWEST, MT_EXTERNAL};
    msg_bad = msg_valid && msg_type inside {MT_FIXED, MT_LOWEST} && msg_vec < MIN_VEC;
    msg_accept = msg_valid && !msg_bad && (sys_type || msg_from_pin
                 || (gated_type && sw_en));
    focus_hit = msg_valid && msg_type == MT_LOWEST && !focus_check_control
                && (in_service_bits[msg_vec] || request_pending_bits[msg_vec]);
  end

  // Error events
  always_comb
  begin
    err_set = 8'h00;
    err_set[ESR_SEND_UNACC] = send_unaccepted;
    err_set[ESR_RECV_UNACC] = recv_unaccepted;
    err_set[ESR_SENT_BAD] = send_bad_vec;
    // Error entry's own bad vector left out: it would loop through err_evt
    for (int e = 0; e < N_ENT; e++)
    begin
      if (e != ENT_ERR)
        err_set[ESR_SENT_BAD] = err_set[ESR_SENT_BAD] | ent_bad[e];
    end
    err_set[ESR_RECV_BAD] = msg_bad;
    err_set[ESR_BAD_REG] = bad_access;
  end

  lves_err u_err (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .set_vec(err_set),
    .capture(esr_wr),
    .int_flags(err_flags),
    .esr(esr),
    .err_evt(err_evt)
  );

  // Priority check at the decision cycle of the acknowledge
  assign spur_hit = task_prio[7:4] >= ack_vec_q[7:4];

  // Acknowledge sequence
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      ack_vec_q <= 8'h00;
      vld_q <= 1'b0;
      spur_out_q <= 1'b0;
      in_service_set_q <= 1'b0;
      cvec_q <= 8'h00;
    end
    else if (ce)
    begin
      vld_q <= 1'b0;
      spur_out_q <= 1'b0;
      in_service_set_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (ack_req)
          begin
            ack_vec_q <= ack_vec;
            st_q <= ST_ACK;
          end
        end
        ST_ACK:
        begin
          vld_q <= 1'b1;
          spur_out_q <= spur_hit;
          in_service_set_q <= !spur_hit;
          cvec_q <= spur_hit ? spur_q[VEC_LSB +: 8] : ack_vec_q;
          st_q <= ST_DONE;
        end
        ST_DONE:
          st_q <= ST_IDLE;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  assign core_vec_valid = vld_q;
  assign core_vec = cvec_q;
  assign core_spurious = spur_out_q;
  assign in_service_set = in_service_set_q;
  assign sw_enabled = sw_en;

  // Checks
  sequence s_ack_dec;
    st_q == ST_ACK && ce;
  endsequence

  property p_spur_vec;
    @(posedge clk_sys) disable iff (rst)
    s_ack_dec and spur_hit |=> core_vec_valid && core_spurious && core_vec == spur_q[7:0];
  endproperty
  a_spur_vec: assert property (p_spur_vec) else $error("spurious vector not delivered");

  property p_no_in_service;
    @(posedge clk_sys) disable iff (rst)
    core_spurious |-> !in_service_set;
  endproperty
  a_no_in_service: assert property (p_no_in_service) else $error("in-service set on spurious");

  property p_normal_ack;
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_IDLE && ack_req && ce) ##1 (s_ack_dec and !spur_hit)
      |=> in_service_set && core_vec == $past(ack_vec, 2);
  endproperty
  a_normal_ack: assert property (p_normal_ack) else $error("normal vector not delivered");

  property p_mask_forced;
    @(posedge clk_sys) disable iff (rst)
    (!sw_en && ce) [*2] |-> ent_val[ENT_PERF][MASK_BIT] && ent_val[ENT_ERR][MASK_BIT];
  endproperty
  a_mask_forced: assert property (p_mask_forced) else $error("mask clear while disabled");

  property p_refuse;
    @(posedge clk_sys) disable iff (rst)
    msg_valid && !sw_en && !msg_from_pin && msg_type == MT_FIXED |-> !msg_accept;
  endproperty
  a_refuse: assert property (p_refuse) else $error("fixed accepted while disabled");

  property p_sys_accept;
    @(posedge clk_sys) disable iff (rst)
    msg_valid && msg_type == MT_NMI |-> msg_accept;
  endproperty
  a_sys_accept: assert property (p_sys_accept) else $error("NMI refused");

  property p_capture;
    @(posedge clk_sys) disable iff (rst)
    esr_wr && ce |=> esr == $past(err_flags);
  endproperty
  a_capture: assert property (p_capture) else $error("status capture wrong");

  property p_bad_reg;
    @(posedge clk_sys) disable iff (rst)
    bad_access && ce |=> err_flags[ESR_BAD_REG];
  endproperty
  a_bad_reg: assert property (p_bad_reg) else $error("bad access not flagged");

  property p_err_edge;
    @(posedge clk_sys) disable iff (rst)
    err_evt |=> (err_flags & ~$past(err_flags)) != 8'h00;
  endproperty
  a_err_edge: assert property (p_err_edge) else $error("error request without new flag");

  property p_focus_off;
    @(posedge clk_sys) disable iff (rst)
    focus_check_control |-> !focus_hit;
  endproperty
  a_focus_off: assert property (p_focus_off) else $error("focus reported with check off");

endmodule

`default_nettype wire

// ### rtl/lves_pkg.sv
/*
  Shared constants for the local vector, error and spurious block:
  register offsets, field positions, reset values and message types.
  Assumes a 12-bit byte address inside the 4 KB register window.
*/
`default_nettype none

package lves_pkg;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_SPUR = 12'h0f0;
  localparam logic [11:0] OFF_ESR = 12'h280;
  localparam logic [11:0] OFF_THERM = 12'h330;
  localparam logic [11:0] OFF_PERF = 12'h340;
  localparam logic [11:0] OFF_ERRV = 12'h370;
  localparam logic [11:0] OFF_FEAT = 12'h400;
  localparam logic [11:0] OFF_EXT_SEL = 12'h410;
  localparam logic [11:0] OFF_EXT_BASE = 12'h500;
  localparam logic [11:0] EXT_STRIDE = 12'h010;

  // Entry indices; extended entries follow the fixed ones
  localparam int ENT_THERM = 0;
  localparam int ENT_PERF = 1;
  localparam int ENT_ERR = 2;
  localparam int N_FIXED_ENT = 3;
  localparam int N_EXT_ENT = 4;
  localparam int N_ENT = N_FIXED_ENT + N_EXT_ENT;

  // Field positions
  localparam int VEC_LSB = 0;
  localparam int MT_LSB = 8;
  localparam int MASK_BIT = 16;
  localparam int DS_BIT = 12;
  localparam int SW_EN_BIT = 8;
  localparam int FOCUS_BIT = 9;
  localparam int EXT_CNT_LSB = 16;
  localparam int ESR_SEND_UNACC = 2;
  localparam int ESR_RECV_UNACC = 3;
  localparam int ESR_SENT_BAD = 5;
  localparam int ESR_RECV_BAD = 6;
  localparam int ESR_BAD_REG = 7;

  // Reset values and limits
  localparam logic [31:0] SPUR_RST = 32'h0000_00ff;
  localparam logic [7:0] ESR_IMPL = 8'hec;
  localparam logic [7:0] MIN_VEC = 8'h10;

  // Message types
  typedef enum logic [2:0] {
    MT_FIXED = 3'h0,
    MT_LOWEST = 3'h1,
    MT_SMI = 3'h2,
    MT_RREAD = 3'h3,
    MT_NMI = 3'h4,
    MT_INIT = 3'h5,
    MT_START = 3'h6,
    MT_EXTERNAL = 3'h7
  } lves_mt_t;

  // Offset of entry e
  function automatic logic [11:0] lves_ent_off(input int e);
    logic [11:0] off;
    off = OFF_EXT_BASE + 12'((e - N_FIXED_ENT) * 16);
    if (e == ENT_THERM) off = OFF_THERM;
    if (e == ENT_PERF) off = OFF_PERF;
    if (e == ENT_ERR) off = OFF_ERRV;
    return off;
  endfunction

endpackage

`default_nettype wire

// ### rtl/lves_lvt.sv
/*
  One local vector entry: vector, message type, mask and a request
  that waits for the core to take it.
  Assumes sw_en comes from the enable bit and take is one-cycle.
*/
`default_nettype none

module lves_entry
  import lves_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic sw_en,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  // Source and delivery
  input wire logic evt,
  input wire logic take,
  output logic [31:0] value,
  output logic pend,
  output logic bad_vec
);

  logic [7:0] vec_q;
  logic [2:0] mt_q;
  logic mask_q;
  logic pend_q;
  logic fire;

  // Entry fields; mask held set while disabled
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      vec_q <= 8'h00;
      mt_q <= 3'h0;
      mask_q <= 1'b1;
    end
    else if (ce)
    begin
      if (wr_en)
      begin
        vec_q <= wr_data[VEC_LSB +: 8];
        mt_q <= wr_data[MT_LSB +: 3];
        mask_q <= wr_data[MASK_BIT] | ~sw_en;
      end
      else if (!sw_en)
        mask_q <= 1'b1;
    end
  end

  // Fixed vector below 16 is refused and reported
  assign fire = evt && !mask_q;
  assign bad_vec = fire && mt_q == MT_FIXED && vec_q < MIN_VEC;

  // Pending request; a new event wins over the take
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pend_q <= 1'b0;
    else if (ce)
      pend_q <= (pend_q && !take) || (fire && !bad_vec);
  end

  assign pend = pend_q;
  assign value = {15'h0000, mask_q, 3'h0, pend_q, 1'b0, mt_q, vec_q};

endmodule

`default_nettype wire

// ### rtl/lves_err.sv
/*
  Internal error flags and the captured error status copy.
  Assumes capture is a one-cycle write strobe to the status register.
*/
`default_nettype none

module lves_err
  import lves_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Error events and capture
  input wire logic [7:0] set_vec,
  input wire logic capture,
  // State
  output logic [7:0] int_flags,
  output logic [7:0] esr,
  output logic err_evt
);

  logic [7:0] int_q;
  logic [7:0] int_d;
  logic [7:0] esr_q;

  // Sticky flag per bit; set wins over capture clear
  for (genvar b = 0; b < 8; b++)
  begin : g_bit
    assign int_d[b] = ESR_IMPL[b] & (set_vec[b] | (int_q[b] & ~capture));
  end

  // Flags and captured copy
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      int_q <= 8'h00;
      esr_q <= 8'h00;
    end
    else if (ce)
    begin
      int_q <= int_d;
      if (capture)
        esr_q <= int_q & ESR_IMPL;
    end
  end

  // Request only on a clear-to-set transition
  assign err_evt = ce && |(int_d & ~int_q);
  assign int_flags = int_q;
  assign esr = esr_q;

endmodule

`default_nettype wire

// ### tb/lves_core_model.sv
/*
  Core-side model of the interrupt handler: takes entry requests and
  records the vector of each one taken.
  Assumes the block holds a request until ready is seen with it.
*/
`default_nettype none

module lves_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bench control
  input wire logic stall,
  // Entry requests
  input wire logic ent_req_valid,
  input wire logic [7:0] ent_req_vec,
  output logic ent_req_ready,
  // Record of takes
  output logic [7:0] last_vec,
  output logic [7:0] take_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  // Ready at once unless told to stall
  assign ent_req_ready = !stall;

  // Count and record each taken request
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      last_vec <= 8'h00;
      take_cnt <= 8'h00;
    end
    else if (ent_req_valid && ent_req_ready)
    begin
      last_vec <= ent_req_vec;
      take_cnt <= take_cnt + 8'h01;
    end
  end
endmodule

`default_nettype wire

// ### tb/test_local_vector_error_spurious.sv
/*
  Self-checking bench: register accesses, source events, error capture,
  acknowledge and message checks.
  Assumes the core model stands at the delivery port.
*/
`default_nettype none

module test_local_vector_error_spurious;
  import lves_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, perf_ovf = 0, thermal_evt = 0;
  logic send_unaccepted = 0, recv_unaccepted = 0, send_bad_vec = 0, msg_valid = 0;
  logic msg_from_pin = 0, ack_req = 0, stall = 0, a, f;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, d;
  logic [3:0] ext_src_evt = '0;
  logic [2:0] msg_type = '0, ent_req_mt;
  logic [7:0] msg_vec = '0, ack_vec = '0, task_prio = '0, ent_req_vec, core_vec, last_vec, take_cnt, cnt0;
  logic [255:0] in_service_bits = '0;
  logic ent_req_valid, ent_req_ready, msg_accept, focus_hit, core_vec_valid, core_spurious, in_service_set;
  logic sw_enabled;
  int num_errors = 0, check_count = 0, cyc = 0;

  lves_top #(.N_EXT_SRC(4)) uut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .perf_ovf(perf_ovf),
    .thermal_evt(thermal_evt), .ext_src_evt(ext_src_evt), .ent_req_valid(ent_req_valid),
    .ent_req_vec(ent_req_vec), .ent_req_mt(ent_req_mt), .ent_req_ready(ent_req_ready),
    .send_unaccepted(send_unaccepted), .recv_unaccepted(recv_unaccepted), .send_bad_vec(send_bad_vec),
    .msg_valid(msg_valid), .msg_type(msg_type), .msg_vec(msg_vec), .msg_from_pin(msg_from_pin),
    .msg_accept(msg_accept), .focus_hit(focus_hit), .in_service_bits(in_service_bits),
    .request_pending_bits(256'h0), .ack_req(ack_req), .ack_vec(ack_vec), .task_prio(task_prio),
    .core_vec_valid(core_vec_valid), .core_vec(core_vec), .core_spurious(core_spurious),
    .in_service_set(in_service_set), .sw_enabled(sw_enabled));

  lves_core_model core (.clk_sys(clk_sys), .rst(rst), .stall(stall), .ent_req_valid(ent_req_valid),
    .ent_req_vec(ent_req_vec), .ent_req_ready(ent_req_ready), .last_vec(last_vec), .take_cnt(take_cnt));

  // 40 MHz clock
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task results();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      results();
    end
  end

  task wr(input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= wd;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task rd(input logic [11:0] ad, output logic [31:0] rv);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask

  // One-cycle event k, then expect n takes of vector v
  task ev(input int k, input logic [7:0] v, input logic [7:0] n);
    @(posedge clk_sys);
    cnt0 = take_cnt;
    case (k)
      0: thermal_evt <= 1'b1;
      1: perf_ovf <= 1'b1;
      2: ext_src_evt <= 4'h1;
      3: send_unaccepted <= 1'b1;
      4: recv_unaccepted <= 1'b1;
      default: send_bad_vec <= 1'b1;
    endcase
    @(posedge clk_sys);
    {thermal_evt, perf_ovf, send_unaccepted, recv_unaccepted, send_bad_vec} <= 5'h00;
    ext_src_evt <= 4'h0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(32'(take_cnt), 32'(cnt0 + n));
    if (n != 0) chk(32'(last_vec), 32'(v));
  endtask

  // Present a message for one cycle
  task msg(input logic [2:0] t, input logic [7:0] v, input logic p);
    @(posedge clk_sys);
    msg_valid <= 1'b1;
    msg_type <= t;
    msg_vec <= v;
    msg_from_pin <= p;
    #1;
    a = msg_accept;
    f = focus_hit;
    @(posedge clk_sys);
    msg_valid <= 1'b0;
  endtask

  // Acknowledge and check what reaches the core
  task ack(input logic [7:0] v, input logic [7:0] p, input logic [7:0] ev_vec, input logic sp);
    @(posedge clk_sys);
    ack_req <= 1'b1;
    ack_vec <= v;
    task_prio <= p;
    @(posedge clk_sys);
    ack_req <= 1'b0;
    for (int i = 0; i < 6 && core_vec_valid !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    chk(32'(core_vec_valid), 32'h1);
    chk(32'(core_vec), 32'(ev_vec));
    chk(32'({core_spurious, in_service_set}), 32'({sp, !sp}));
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFF_SPUR, d);
    chk(d, SPUR_RST);
    rd(OFF_FEAT, d);
    chk(32'(d[23:16]), 32'h4);
    wr(OFF_PERF, 32'h0000_0040);
    rd(OFF_PERF, d);
    chk(d, 32'h0001_0040);
    ev(1, 8'h00, 8'h0);
    msg(MT_FIXED, 8'h40, 1'b0);
    chk(32'(a), 32'h0);
    msg(MT_NMI, 8'h00, 1'b0);
    chk(32'(a), 32'h1);
    msg(MT_FIXED, 8'h40, 1'b1);
    chk(32'(a), 32'h1);
    wr(OFF_SPUR, 32'h0000_013f);
    chk(32'(sw_enabled), 32'h1);
    // Entries, extended source 0 steered to extended entry 3
    wr(OFF_THERM, 32'h0000_0430);
    wr(OFF_PERF, 32'h0000_0040);
    wr(OFF_EXT_SEL, 32'h0000_0003);
    wr(OFF_EXT_BASE + 12'h030, 32'h0000_0070);
    rd(OFF_PERF, d);
    chk(d, 32'h0000_0040);
    ev(0, 8'h30, 8'h1);
    ev(1, 8'h40, 8'h1);
    ev(2, 8'h70, 8'h1);
    wr(OFF_PERF, 32'h0001_0040);
    ev(1, 8'h00, 8'h0);
    // Slow core: request stands until taken, pending bit shows it
    stall <= 1'b1;
    ev(0, 8'h00, 8'h0);
    chk(32'(ent_req_valid), 32'h1);
    chk(32'({ent_req_mt, ent_req_vec}), 32'({MT_NMI, 8'h30}));
    rd(OFF_THERM, d);
    chk(d, 32'h0000_1430);
    stall <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(32'(take_cnt), 32'(cnt0 + 8'h1));
    // Illegal vector in an entry, error entry still masked
    wr(OFF_THERM, 32'h0000_0005);
    ev(0, 8'h00, 8'h0);
    wr(OFF_ERRV, 32'h0000_0050);
    ev(3, 8'h50, 8'h1);
    ev(3, 8'h50, 8'h0);
    ev(4, 8'h50, 8'h1);
    msg(MT_FIXED, 8'h05, 1'b0);
    chk(32'(a), 32'h0);
    rd(12'h004, d);
    chk(d, 32'h0);
    wr(OFF_ESR, 32'h0);
    rd(OFF_ESR, d);
    chk(d, 32'h0000_00ec);
    ev(5, 8'h50, 8'h1);
    wr(OFF_ESR, 32'h0);
    rd(OFF_ESR, d);
    chk(d, 32'h0000_0020);
    wr(OFF_ESR, 32'h0);
    rd(OFF_ESR, d);
    chk(d, 32'h0);
    // Acknowledge at, above and below the task level
    ack(8'h80, 8'h90, 8'h3f, 1'b1);
    ack(8'h80, 8'h80, 8'h3f, 1'b1);
    ack(8'h80, 8'h20, 8'h80, 1'b0);
    // Focus with and without checking
    in_service_bits[8'h60] <= 1'b1;
    msg(MT_LOWEST, 8'h60, 1'b0);
    chk(32'(f), 32'h1);
    wr(OFF_SPUR, 32'h0000_033f);
    msg(MT_LOWEST, 8'h60, 1'b0);
    chk(32'(f), 32'h0);
    wr(OFF_SPUR, 32'h0000_003f);
    rd(OFF_THERM, d);
    chk(d, 32'h0001_0005);
    results();
  end
endmodule

`default_nettype wire
